// [otl_map.vh]
// Offsets, fields, reset values and timing counts of the option and trim loader
// Overview of operation
// RULE1: Bit 7 of the start-up option byte is reserved and is left programmed to one by whoever programs flash.
// RULE2: A zero low-power start-up option starts the part with its clock divided by eight and flash reached only in the second half of the last divide cycle.
// The code raises flash_access_en for the whole last divide cycle, together with sys_clk_en.
// RULE3: A one low-power start-up option starts the part normally, with no divide and no restricted flash timing.
// RULE4: Bits 5 to 0 of the start-up option byte are reserved and are programmed to all ones.
// RULE5: The information area cannot be written directly; factory settings change only through the trim registers.
// RULE6: Every reset puts the factory values back into the trim registers, so software rewrites them after each reset.
// RULE7: Reads of the information area addresses return the stored factory values even after the trim registers change.
// RULE8: At reset the oscillator trim values at information locations 0021h and 0022h are copied into the two oscillator trim registers.
// RULE9: At reset the ADC reference trim value at information location 0023h is copied into the ADC reference trim register.
// RULE10: The three upper bits of the ADC reference trim byte are reserved and writers keep them at one.
// RULE11: The five-bit ADC reference trim field adjusts the reference; an untrimmed part holds F0h in the whole register.
// RULE12: All option and trim loads finish before the processor is released from reset.
`ifndef OTL_MAP_VH
`define OTL_MAP_VH
`define OTL_PM_OPTION_ADDR 16'h0003
`define OTL_INFO_OSC1_ADDR 16'h0021
`define OTL_INFO_OSC2_ADDR 16'h0022
`define OTL_INFO_ADC_ADDR 16'h0023
`define OTL_OSC1_OFFS 32'hFFFFFF25
`define OTL_OSC2_OFFS 32'hFFFFFF26
`define OTL_ADC_OFFS 32'hFFFFFF27
`define OTL_REG_OPTION 12'h000
`define OTL_REG_OSC1 12'h004
`define OTL_REG_OSC2 12'h008
`define OTL_REG_ADC 12'h00C
`define OTL_REG_STATUS 12'h010
`define OTL_REG_INFO_OSC1 12'h020
`define OTL_REG_INFO_OSC2 12'h024
`define OTL_REG_INFO_ADC 12'h028
`define OTL_LOW_POWER_STARTUP_OPTION_BIT 6
`define OTL_ADC_RSV_MASK 8'hE0
`define OTL_ADC_UNTRIMMED 8'hF0
`define OTL_OPTION_ERASED 8'hFF
`define OTL_LP_DIVIDE 4'h8
`define OTL_MEM_LATENCY 3'h2
`define OTL_RESP_OKAY 2'h0
`define OTL_RESP_SLVERR 2'h2
`endif

// [otl_info_rom.v]
// Factory information area and option byte, read-only, registered read data
`include "otl_map.vh"
`timescale 1ns/1ps
module otl_info_rom #(
   parameter [7:0] OPTION_VALUE = 8'hFF,
   parameter [7:0] OSC1_VALUE = 8'h80,
   parameter [7:0] OSC2_VALUE = 8'h80,
   parameter [7:0] ADC_VALUE = 8'hF0
) (
   input wire core_clk,
   input wire arst_n,
   input wire [15:0] rd_addr,
   output reg [7:0] rd_data
);
   // No write port exists: factory contents are fixed
   always @(posedge core_clk or negedge arst_n) begin // RULE5
      if (!arst_n) begin
         rd_data <= 8'h00;
      end else begin
         case (rd_addr)
            `OTL_PM_OPTION_ADDR: rd_data <= OPTION_VALUE;
            `OTL_INFO_OSC1_ADDR: rd_data <= OSC1_VALUE;
            `OTL_INFO_OSC2_ADDR: rd_data <= OSC2_VALUE;
            `OTL_INFO_ADC_ADDR: rd_data <= ADC_VALUE;
            default: rd_data <= 8'hFF;
         endcase
      end
   end
endmodule // otl_info_rom

// [otl_loader.v]
// Reset-time option and trim loader with AXI4-Lite register access
//
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "otl_map.vh"
module otl_loader #(
   parameter [7:0] OPTION_VALUE = 8'hFF,
   parameter [7:0] OSC1_VALUE = 8'h80,
   parameter [7:0] OSC2_VALUE = 8'h80,
   parameter [7:0] ADC_VALUE = 8'hF0
) (
   input wire core_clk,
   input wire arst_n,
   input wire [11:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [11:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   output reg cpu_reset_n,
   output reg low_power_mode,
   output reg flash_access_en,
   output reg sys_clk_en,
   output reg [7:0] oscillator_trim_first,
   output reg [7:0] oscillator_trim_second,
   output reg [7:0] adc_reference_trim_reg
);
   localparam [2:0] ST_OPT = 3'h0;
   localparam [2:0] ST_OSC1 = 3'h1;
   localparam [2:0] ST_OSC2 = 3'h2;
   localparam [2:0] ST_ADC = 3'h3;
   localparam [2:0] ST_WAIT = 3'h4;
   localparam [2:0] ST_RUN = 3'h5;

   reg [2:0] state_reg;
   reg [2:0] state_next;
   reg [1:0] step_reg;
   reg [15:0] rom_addr;
   wire [7:0] rom_data;
   reg [7:0] option_reg;
   reg [7:0] info_osc1_reg;
   reg [7:0] info_osc2_reg;
   reg [7:0] info_adc_reg;
   reg [3:0] div_reg;
   reg aw_held_reg;
   reg w_held_reg;
   reg [11:0] awaddr_reg;
   reg [31:0] wdata_reg;
   reg [3:0] wstrb_reg;
   reg rst_meta_reg;
   reg rst_sync_reg;
   wire core_rst_n;
   wire loaded;

   // Release is synchronised so every register leaves reset on one edge
   always @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         rst_meta_reg <= 1'b0;
         rst_sync_reg <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_sync_reg <= rst_meta_reg;
      end
   end

   // Only the second stage drives logic; the first may be metastable
   assign core_rst_n = rst_sync_reg;

   otl_info_rom #(
      .OPTION_VALUE(OPTION_VALUE),
      .OSC1_VALUE(OSC1_VALUE),
      .OSC2_VALUE(OSC2_VALUE),
      .ADC_VALUE(ADC_VALUE)
   ) u_rom (
      .core_clk(core_clk),
      .arst_n(core_rst_n),
      .rd_addr(rom_addr),
      .rd_data(rom_data)
   );

   // Byte-lane merge of a software write into an 8-bit register
   function [7:0] lane_merge;
      input [7:0] old_val;
      input [31:0] data;
      input [3:0] strb;
      begin
         lane_merge = strb[0] ? data[7:0] : old_val;
      end
   endfunction

   // Only the three trim registers accept software writes
   function is_trim_addr;
      input [11:0] addr;
      begin
         is_trim_addr = (addr == `OTL_REG_OSC1) || (addr == `OTL_REG_OSC2) ||
                        (addr == `OTL_REG_ADC);
      end
   endfunction

   always @* begin
      rom_addr = `OTL_PM_OPTION_ADDR;
      case (state_reg)
         ST_OPT: rom_addr = `OTL_PM_OPTION_ADDR;
         ST_OSC1: rom_addr = `OTL_INFO_OSC1_ADDR;
         ST_OSC2: rom_addr = `OTL_INFO_OSC2_ADDR;
         ST_ADC: rom_addr = `OTL_INFO_ADC_ADDR;
         default: rom_addr = `OTL_PM_OPTION_ADDR;
      endcase
   end

   // Each location is held for two cycles so the registered ROM data settle
   wire step_done = (step_reg == (`OTL_MEM_LATENCY - 3'h1));

   always @* begin
      state_next = state_reg;
      case (state_reg)
         ST_OPT: if (step_done) state_next = ST_OSC1;
         ST_OSC1: if (step_done) state_next = ST_OSC2;
         ST_OSC2: if (step_done) state_next = ST_ADC;
         ST_ADC: if (step_done) state_next = ST_WAIT;
         ST_WAIT: state_next = ST_RUN;
         ST_RUN: state_next = ST_RUN;
         default: state_next = ST_OPT;
      endcase
   end

   assign loaded = (state_reg == ST_RUN);

   // Loads restart from the factory copy at every reset
   always @(posedge core_clk or negedge core_rst_n) begin // RULE6
      if (!core_rst_n) begin
         state_reg <= ST_OPT;
         step_reg <= 2'h0;
         option_reg <= `OTL_OPTION_ERASED;
         info_osc1_reg <= 8'h00;
         info_osc2_reg <= 8'h00;
         info_adc_reg <= `OTL_ADC_UNTRIMMED;
      end else begin
         state_reg <= state_next;
         if (step_done || state_reg >= ST_WAIT) begin
            step_reg <= 2'h0;
         end else begin
            step_reg <= step_reg + 2'h1;
         end
         if (step_done) begin
            case (state_reg)
               ST_OPT: option_reg <= rom_data;
               ST_OSC1: info_osc1_reg <= rom_data; // RULE8
               ST_OSC2: info_osc2_reg <= rom_data; // RULE8
               ST_ADC: info_adc_reg <= rom_data; // RULE9
               default: info_adc_reg <= info_adc_reg;
            endcase
         end
      end
   end

   // Processor stays in reset until every load is done
   // Held low one cycle past the trim load so the processor never sees a stale trim
   always @(posedge core_clk or negedge core_rst_n) begin // RULE12
      if (!core_rst_n) begin
         cpu_reset_n <= 1'b0;
      end else begin
         cpu_reset_n <= loaded;
      end
   end

   // Clock divide: enable one cycle in eight, flash only on that last cycle
   // Counter runs free so the divide phase costs no extra decode
   always @(posedge core_clk or negedge core_rst_n) begin
      if (!core_rst_n) begin
         div_reg <= 4'h0;
         low_power_mode <= 1'b0;
         sys_clk_en <= 1'b0;
         flash_access_en <= 1'b0;
      end else begin
         low_power_mode <= ~option_reg[`OTL_LOW_POWER_STARTUP_OPTION_BIT];
         if (div_reg == (`OTL_LP_DIVIDE - 4'h1)) begin
            div_reg <= 4'h0;
         end else begin
            div_reg <= div_reg + 4'h1;
         end
         if (!loaded) begin
            sys_clk_en <= 1'b0;
            flash_access_en <= 1'b0;
         end else if (!option_reg[`OTL_LOW_POWER_STARTUP_OPTION_BIT]) begin
            sys_clk_en <= (div_reg == (`OTL_LP_DIVIDE - 4'h2)); // RULE2
            flash_access_en <= (div_reg == (`OTL_LP_DIVIDE - 4'h2)); // RULE2
         end else begin
            sys_clk_en <= 1'b1; // RULE3
            flash_access_en <= 1'b1; // RULE3
         end
      end
   end

   // Write channel: address and data taken in either order
   // No new request is taken while a response waits for bready
   always @(posedge core_clk or negedge core_rst_n) begin
      if (!core_rst_n) begin
         aw_held_reg <= 1'b0;
         w_held_reg <= 1'b0;
         awaddr_reg <= 12'h000;
         wdata_reg <= 32'h00000000;
         wstrb_reg <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `OTL_RESP_OKAY;
      end else begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         if (!aw_held_reg && s_axi_awvalid && !s_axi_awready && !s_axi_bvalid) begin
            aw_held_reg <= 1'b1;
            awaddr_reg <= s_axi_awaddr;
            s_axi_awready <= 1'b1;
         end
         if (!w_held_reg && s_axi_wvalid && !s_axi_wready && !s_axi_bvalid) begin
            w_held_reg <= 1'b1;
            wdata_reg <= s_axi_wdata;
            wstrb_reg <= s_axi_wstrb;
            s_axi_wready <= 1'b1;
         end
         if (aw_held_reg && w_held_reg) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            s_axi_bvalid <= 1'b1;
            if (is_trim_addr(awaddr_reg)) begin
               s_axi_bresp <= `OTL_RESP_OKAY;
            end else begin
               // Factory copy and option byte refuse writes
               s_axi_bresp <= `OTL_RESP_SLVERR; // RULE5
            end
         end
      end
   end

   // Trim registers: factory copy after load, software rewrites later
   // Limitation: writes before the load ends answer okay but change nothing
   always @(posedge core_clk or negedge core_rst_n) begin
      if (!core_rst_n) begin
         oscillator_trim_first <= 8'h00;
         oscillator_trim_second <= 8'h00;
         adc_reference_trim_reg <= `OTL_ADC_UNTRIMMED; // RULE11
      end else if (state_reg == ST_WAIT) begin
         oscillator_trim_first <= info_osc1_reg; // RULE8
         oscillator_trim_second <= info_osc2_reg; // RULE8
         adc_reference_trim_reg <= info_adc_reg; // RULE9
      end else if (loaded && aw_held_reg && w_held_reg) begin
         case (awaddr_reg)
            `OTL_REG_OSC1:
               oscillator_trim_first <= lane_merge(oscillator_trim_first, wdata_reg, wstrb_reg);
            `OTL_REG_OSC2:
               oscillator_trim_second <= lane_merge(oscillator_trim_second, wdata_reg,
                                                    wstrb_reg);
            // Whole byte stored; upper bits are the writer's to keep set
            `OTL_REG_ADC:
               adc_reference_trim_reg <= lane_merge(adc_reference_trim_reg, wdata_reg,
                                                    wstrb_reg); // RULE11
            default: adc_reference_trim_reg <= adc_reference_trim_reg;
         endcase
      end
   end

   // Read channel: one-cycle answer after the address is taken
   // Reads during the load show partial state; status bit 0 tells software
   always @(posedge core_clk or negedge core_rst_n) begin
      if (!core_rst_n) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `OTL_RESP_OKAY;
      end else begin
         s_axi_arready <= 1'b0;
         if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end else if (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `OTL_RESP_OKAY;
            case (s_axi_araddr)
               `OTL_REG_OPTION: s_axi_rdata <= {24'h000000, option_reg};
               `OTL_REG_OSC1: s_axi_rdata <= {24'h000000, oscillator_trim_first};
               `OTL_REG_OSC2: s_axi_rdata <= {24'h000000, oscillator_trim_second};
               `OTL_REG_ADC: s_axi_rdata <= {24'h000000, adc_reference_trim_reg};
               `OTL_REG_STATUS: s_axi_rdata <= {30'h00000000, low_power_mode, loaded};
               `OTL_REG_INFO_OSC1: s_axi_rdata <= {24'h000000, info_osc1_reg}; // RULE7
               `OTL_REG_INFO_OSC2: s_axi_rdata <= {24'h000000, info_osc2_reg}; // RULE7
               `OTL_REG_INFO_ADC: s_axi_rdata <= {24'h000000, info_adc_reg}; // RULE7
               default: begin
                  s_axi_rdata <= 32'h00000000;
                  s_axi_rresp <= `OTL_RESP_SLVERR;
               end
            endcase
         end
      end
   end
endmodule // otl_loader

// [otl_loader_props.sv]
// Assertion checker for the option and trim loader
`timescale 1ns/1ps
`include "otl_map.vh"
module otl_props #(
   parameter [7:0] OPTION_VALUE = 8'hFF,
   parameter [7:0] OSC1_VALUE = 8'h80,
   parameter [7:0] OSC2_VALUE = 8'h80,
   parameter [7:0] ADC_VALUE = 8'hF0
) (
   input wire core_clk,
   input wire arst_n,
   input wire [11:0] s_axi_araddr,
   input wire [31:0] s_axi_rdata,
   input wire s_axi_rvalid,
   input wire s_axi_bvalid,
   input wire cpu_reset_n,
   input wire low_power_mode,
   input wire flash_access_en,
   input wire sys_clk_en,
   input wire [7:0] oscillator_trim_first,
   input wire [7:0] oscillator_trim_second,
   input wire [7:0] adc_reference_trim_reg
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!arst_n);
   property p_mode;
      cpu_reset_n |-> low_power_mode == !OPTION_VALUE[6];
   endproperty
   a_mode: assert property (p_mode)
      else $error("start-up mode differs from option bit");
   property p_div;
      low_power_mode && sys_clk_en |=> !sys_clk_en [*7] ##1 sys_clk_en;
   endproperty
   a_div: assert property (p_div)
      else $error("clock enable not one cycle in eight");
   property p_flash;
      cpu_reset_n |-> flash_access_en == sys_clk_en;
   endproperty
   a_flash: assert property (p_flash)
      else $error("flash access outside final divide cycle");
   property p_load_osc;
      $rose(cpu_reset_n) |-> {oscillator_trim_first, oscillator_trim_second}
         == {OSC1_VALUE, OSC2_VALUE};
   endproperty
   a_load_osc: assert property (p_load_osc)
      else $error("oscillator trims not loaded at release");
   property p_load_adc;
      $rose(cpu_reset_n) |-> adc_reference_trim_reg == ADC_VALUE;
   endproperty
   a_load_adc: assert property (p_load_adc)
      else $error("reference trim not loaded at release");
   property p_hold;
      cpu_reset_n ##1 !$stable({oscillator_trim_first, oscillator_trim_second,
         adc_reference_trim_reg}) |-> $rose(s_axi_bvalid);
   endproperty
   a_hold: assert property (p_hold)
      else $error("trim changed without a write");
   property p_info_adc;
      $rose(s_axi_rvalid) && $past(s_axi_araddr) == `OTL_REG_INFO_ADC
         |-> s_axi_rdata == {24'h000000, ADC_VALUE};
   endproperty
   a_info_adc: assert property (p_info_adc)
      else $error("factory reference value not returned");
   property p_info_osc;
      $rose(s_axi_rvalid) && $past(s_axi_araddr) == `OTL_REG_INFO_OSC1
         |-> s_axi_rdata == {24'h000000, OSC1_VALUE};
   endproperty
   a_info_osc: assert property (p_info_osc)
      else $error("factory oscillator value not returned");
endmodule // otl_props
bind otl_loader otl_props #(.OPTION_VALUE(OPTION_VALUE), .OSC1_VALUE(OSC1_VALUE),
   .OSC2_VALUE(OSC2_VALUE), .ADC_VALUE(ADC_VALUE)) i_otl_props (.core_clk(core_clk),
   .arst_n(arst_n), .s_axi_araddr(s_axi_araddr), .s_axi_rdata(s_axi_rdata),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_bvalid(s_axi_bvalid), .cpu_reset_n(cpu_reset_n),
   .low_power_mode(low_power_mode), .flash_access_en(flash_access_en),
   .sys_clk_en(sys_clk_en), .oscillator_trim_first(oscillator_trim_first),
   .oscillator_trim_second(oscillator_trim_second),
   .adc_reference_trim_reg(adc_reference_trim_reg));

// [tb_top.sv]
// Self-checking bench for the option and trim loader
`timescale 1ns/1ps
`include "otl_map.vh"
module tb_top;
   localparam [7:0] OPT = 8'hBF;
   localparam [7:0] F1 = 8'h5A;
   localparam [7:0] F2 = 8'hA5;
   localparam [7:0] FA = 8'hF3;
   logic core_clk = 1'h0;
   logic arst_n = 1'h0;
   logic [11:0] awa = 12'h000;
   logic [11:0] ara = 12'h000;
   logic [31:0] wd = 32'h0;
   logic [3:0] ws = 4'hF;
   logic awv = 1'h0, wv = 1'h0, br = 1'h0, arv = 1'h0, rr = 1'h0;
   wire awr, wrd, bv, arr, rv, cpu_n, lpm, fen, cen;
   wire [1:0] bresp, rresp;
   wire [31:0] rdata;
   wire [7:0] t1, t2, ta;
   int n_errors = 0;
   int comparisons = 0;
   logic [33:0] rq[$];
   logic [1:0] bq[$];
   otl_loader #(.OPTION_VALUE(OPT), .OSC1_VALUE(F1), .OSC2_VALUE(F2), .ADC_VALUE(FA))
   i_otl_loader (.core_clk(core_clk), .arst_n(arst_n), .s_axi_awaddr(awa),
      .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws),
      .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
      .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr),
      .cpu_reset_n(cpu_n), .low_power_mode(lpm), .flash_access_en(fen),
      .sys_clk_en(cen), .oscillator_trim_first(t1), .oscillator_trim_second(t2),
      .adc_reference_trim_reg(ta));
   initial forever #25 core_clk = ~core_clk;
   task chk(input logic [33:0] e, input logic [33:0] g);
      comparisons++;
      if (g !== e) begin
         n_errors++;
         $display("mismatch at %0t: expected %h got %h", $time, e, g);
      end
   endtask
   task close_out;
      $display("comparisons %0d errors %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // Each channel drops its own valid or ready once the slave has answered
   always @(posedge core_clk) begin
      if (awr === 1'h1) awv <= 1'h0;
      if (wrd === 1'h1) wv <= 1'h0;
      if (arr === 1'h1) arv <= 1'h0;
      if (bv === 1'h1) br <= 1'h0;
      if (rv === 1'h1) rr <= 1'h0;
   end
   always @(posedge core_clk) begin
      if (rv === 1'h1 && rr === 1'h1) chk(rq.pop_front(), {rresp, rdata});
      if (bv === 1'h1 && br === 1'h1) chk({32'h0, bq.pop_front()}, {32'h0, bresp});
   end
   task wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
      @(posedge core_clk);
      bq.push_back(r);
      awa <= a;
      wd <= d;
      awv <= 1'h1;
      wv <= 1'h1;
      br <= 1'h1;
      @(posedge core_clk);
      while (br !== 1'h0) @(posedge core_clk);
   endtask
   task rd(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
      @(posedge core_clk);
      rq.push_back({r, d});
      ara <= a;
      arv <= 1'h1;
      rr <= 1'h1;
      @(posedge core_clk);
      while (rr !== 1'h0) @(posedge core_clk);
   endtask
   // Trims are sampled at the first edge that sees the processor released
   task ld;
      while (cpu_n !== 1'h1) @(posedge core_clk);
      chk({10'h0, F1, F2, FA}, {10'h0, t1, t2, ta});
      rd(`OTL_REG_OSC1, {24'h0, F1}, `OTL_RESP_OKAY);
      rd(`OTL_REG_OSC2, {24'h0, F2}, `OTL_RESP_OKAY);
      rd(`OTL_REG_ADC, {24'h0, FA}, `OTL_RESP_OKAY);
   endtask
   initial begin
      repeat (3000) @(posedge core_clk);
      n_errors++;
      close_out();
   end
   initial begin
      int gap;
      logic [31:0] v;
      void'($urandom(32'h0115));
      repeat (8) @(posedge core_clk);
      arst_n <= 1'h1;
      ld();
      rd(`OTL_REG_OPTION, {24'h0, OPT}, `OTL_RESP_OKAY);
      rd(`OTL_REG_STATUS, 32'h3, `OTL_RESP_OKAY);
      while (cen !== 1'h1) @(posedge core_clk);
      @(posedge core_clk);
      for (gap = 1; cen !== 1'h1; gap++) @(posedge core_clk);
      chk(34'h8, 34'(gap));
      chk(34'h3, {32'h0, fen, lpm});
      for (int i = 0; i < 4; i++) begin
         v = $urandom;
         wr(`OTL_REG_OSC1, v, `OTL_RESP_OKAY);
         wr(`OTL_REG_OSC2, ~v, `OTL_RESP_OKAY);
         wr(`OTL_REG_ADC, {v[31:8], 3'h7, v[4:0]}, `OTL_RESP_OKAY);
         rd(`OTL_REG_OSC1, {24'h0, v[7:0]}, `OTL_RESP_OKAY);
         rd(`OTL_REG_ADC, {24'h0, 3'h7, v[4:0]}, `OTL_RESP_OKAY);
         rd(`OTL_REG_INFO_OSC1, {24'h0, F1}, `OTL_RESP_OKAY);
         chk({10'h0, v[7:0], ~v[7:0], 3'h7, v[4:0]}, {10'h0, t1, t2, ta});
      end
      ws <= 4'hE;
      wr(`OTL_REG_OSC1, ~v, `OTL_RESP_OKAY);
      ws <= 4'hF;
      rd(`OTL_REG_OSC1, {24'h0, v[7:0]}, `OTL_RESP_OKAY);
      wr(`OTL_REG_ADC, 32'hF0, `OTL_RESP_OKAY);
      rd(`OTL_REG_ADC, 32'hF0, `OTL_RESP_OKAY);
      wr(`OTL_REG_INFO_ADC, 32'h0, `OTL_RESP_SLVERR);
      wr(`OTL_REG_OPTION, 32'h0, `OTL_RESP_SLVERR);
      rd(`OTL_REG_INFO_ADC, {24'h0, FA}, `OTL_RESP_OKAY);
      rd(12'h0FC, 32'h0, `OTL_RESP_SLVERR);
      @(posedge core_clk);
      arst_n <= 1'h0;
      repeat (3) @(posedge core_clk);
      arst_n <= 1'h1;
      ld();
      close_out();
   end
endmodule // tb_top
